// ---- hw/rsdpm_pkg.sv ----
package rsdpm_pkg;

  localparam int NUM_CHANNELS = 3;
  localparam int NIBBLE_WIDTH = 4;
  localparam int HDLC_WIDTH = 8;
  localparam int SYNC_STAGES = 2;

  // Bus bit carried by each shared pin
  localparam int FRAME_LOSS_BIT = 1;
  localparam int RED_ALARM_BIT = 3;

  // Status word that crosses into the link domain
  localparam int LOS_POS = 0;
  localparam int OOF_POS = 1;
  localparam int AIS_POS = 2;
  localparam int MODE_POS = 3;
  localparam int MODE_WIDTH = 2;
  localparam int STATUS_WIDTH = 5;

  // Reset values
  localparam logic PIN_RESET = 1'b0;
  localparam logic CLOCK_RESET = 1'b0;
  localparam logic [NIBBLE_WIDTH-1:0] NIBBLE_RESET = 4'h0;
  localparam logic [HDLC_WIDTH-1:0] HDLC_RESET = 8'h00;
  localparam logic [STATUS_WIDTH-1:0] STATUS_RESET = 5'h00;

  // Nibble and HDLC differ in one bit so a switch between them is clean
  typedef enum logic [MODE_WIDTH-1:0] {
    MODE_OTHER = 2'h0,
    MODE_NIBBLE = 2'h1,
    MODE_HDLC = 2'h3
  } rsdpm_mode_type;

endpackage

// ---- hw/rsdpm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module rsdpm_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = rsdpm_pkg::SYNC_STAGES
) (
  input wire logic clk,
  input wire logic rst,
  rsdpm_sync_if.sync port
);
  import rsdpm_pkg::*;

  generate
    if (STAGES < 2 || WIDTH < 1) begin : gBadParam
      $error("rsdpm_sync needs at least two stages and one bit");
    end
  endgenerate

  logic [WIDTH-1:0] stage_reg [STAGES];
  logic [WIDTH-1:0] stage_next [STAGES];

  // First stage feeds only the second stage
  always_comb begin
    stage_next[0] = port.asyncIn;
    for (int i = 1; i < STAGES; i++) begin
      stage_next[i] = stage_reg[i-1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign port.syncOut = stage_reg[STAGES-1];

endmodule

`default_nettype wire

// ---- hw/rsdpm_sync_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface rsdpm_sync_if #(
  parameter int WIDTH = 1
);
  logic [WIDTH-1:0] asyncIn;
  logic [WIDTH-1:0] syncOut;

  modport sync (
    input asyncIn,
    output syncOut
  );
  modport user (
    output asyncIn,
    input syncOut
  );
endinterface

`default_nettype wire

// ---- hw/rsdpm_top.sv ----
// Behaviour
// (RULE1) Each shared pin function is chosen by mode: nibble, HDLC, or alarm.
// (RULE2) In alarm modes red pin is high while any framer defect is declared.
// (RULE3) Alarm indication signal defect also drives the red pin high.
// (RULE4) Red pin is low when no LOS, OOF or AIS defect is declared.
// (RULE5) Nibble mode: pin carries bit 1 of the four-bit receive nibble bus.
// (RULE6) Nibble bits change only at the rising edge of the line clock out.
// (RULE7) Terminal equipment samples nibble bits on the line clock falling edge.
// (RULE8) HDLC mode: pin carries bit 1 of the byte-wide HDLC frame bus.
// (RULE9) HDLC byte bus updates at the rising edge of the HDLC clock out.
// (RULE10) Terminal equipment samples HDLC bus on the HDLC clock falling edge.
// (RULE11) Other modes: frame-loss pin is high while framer declares OOF.
// (RULE12) Frame-loss pin falls once the framer regains frame alignment.
// (RULE13) Nibble and HDLC outputs are held inactive outside their modes.
// (RULE14) Every channel has its own independent copy of this pin logic.
`timescale 1ns/1ps
`default_nettype none

module rsdpm_top #(
  parameter int NUM_CHANNELS = rsdpm_pkg::NUM_CHANNELS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic linkClk,
  input wire rsdpm_pkg::rsdpm_mode_type [NUM_CHANNELS-1:0] channelMode,
  input wire logic [NUM_CHANNELS-1:0] losDefect,
  input wire logic [NUM_CHANNELS-1:0] oofDefect,
  input wire logic [NUM_CHANNELS-1:0] aisDefect,
  input wire logic [NUM_CHANNELS-1:0][rsdpm_pkg::NIBBLE_WIDTH-1:0] nibbleData,
  input wire logic [NUM_CHANNELS-1:0] nibbleValid,
  input wire logic [NUM_CHANNELS-1:0][rsdpm_pkg::HDLC_WIDTH-1:0] hdlcData,
  input wire logic [NUM_CHANNELS-1:0] hdlcValid,
  output wire logic [NUM_CHANNELS-1:0] rxRedAlarmOut,
  output wire logic [NUM_CHANNELS-1:0] rxFrameLossOut,
  output wire logic [NUM_CHANNELS-1:0][rsdpm_pkg::NIBBLE_WIDTH-1:0] rxNibbleBus,
  output wire logic [NUM_CHANNELS-1:0][rsdpm_pkg::HDLC_WIDTH-1:0] rxHdlcByteBus,
  output wire logic [NUM_CHANNELS-1:0] rxLineClockOut,
  output wire logic [NUM_CHANNELS-1:0] rxHdlcClockOut
);
  import rsdpm_pkg::*;

  generate
    if (NUM_CHANNELS < 1) begin : gBadParam
      $error("rsdpm_top needs at least one channel");
    end
    if (STATUS_WIDTH < MODE_POS + MODE_WIDTH) begin : gBadStatus
      $error("rsdpm_top status word is too narrow for its fields");
    end
    if (RED_ALARM_BIT >= NIBBLE_WIDTH) begin : gBadRedBit
      $error("rsdpm_top red alarm bit lies outside the nibble bus");
    end
    if (FRAME_LOSS_BIT >= NIBBLE_WIDTH) begin : gBadLossBit
      $error("rsdpm_top frame loss bit lies outside the nibble bus");
    end
  endgenerate

  function automatic logic pinSelect(
    input rsdpm_mode_type mode,
    input logic nibbleBit,
    input logic hdlcBit,
    input logic alarm
  );
    logic result;
    result = alarm;
    case (mode)
      MODE_NIBBLE: result = nibbleBit;
      MODE_HDLC: result = hdlcBit;
      default: result = alarm;
    endcase
    return result;
  endfunction

  genvar c;
  generate
    for (c = 0; c < NUM_CHANNELS; c++) begin : gChannel // RULE14
      logic [STATUS_WIDTH-1:0] status_reg;
      logic [STATUS_WIDTH-1:0] status_next;
      logic [STATUS_WIDTH-1:0] statusSync;
      rsdpm_mode_type mode;
      rsdpm_mode_type syncMode;
      rsdpm_mode_type modeSeen_reg;
      rsdpm_mode_type modeSeen_next;
      rsdpm_mode_type mode_reg;
      rsdpm_mode_type mode_next;
      logic nibbleActive;
      logic hdlcActive;
      logic anyDefect;
      logic lineClk_reg;
      logic lineClk_next;
      logic hdlcClk_reg;
      logic hdlcClk_next;
      logic [NIBBLE_WIDTH-1:0] nibble_reg;
      logic [NIBBLE_WIDTH-1:0] nibble_next;
      logic [HDLC_WIDTH-1:0] hdlc_reg;
      logic [HDLC_WIDTH-1:0] hdlc_next;
      logic red_reg;
      logic red_next;
      logic frameLoss_reg;
      logic frameLoss_next;

      // Launch flops so framer glitches never reach the crossing
      always_comb begin
        status_next = STATUS_RESET;
        status_next[LOS_POS] = losDefect[c];
        status_next[OOF_POS] = oofDefect[c];
        status_next[AIS_POS] = aisDefect[c];
        status_next[MODE_POS +: MODE_WIDTH] = channelMode[c];
      end

      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          status_reg <= STATUS_RESET;
        end else begin
          status_reg <= status_next;
        end
      end

      // Defect bits are independent levels and may cross one by one
      rsdpm_sync_if #(.WIDTH(STATUS_WIDTH)) statusLink ();
      assign statusLink.asyncIn = status_reg;
      assign statusSync = statusLink.syncOut;

      rsdpm_sync #(
        .WIDTH(STATUS_WIDTH),
        .STAGES(SYNC_STAGES)
      ) uStatusSync (
        .clk(linkClk),
        .rst(rst),
        .port(statusLink)
      );

      // The two mode bits may resolve one link cycle apart, which would
      // flash a wrong function; a new mode counts once two samples agree
      always_comb begin
        syncMode = rsdpm_mode_type'(statusSync[MODE_POS +: MODE_WIDTH]);
        modeSeen_next = syncMode;
        mode_next = mode_reg;
        if (syncMode == modeSeen_reg) begin
          mode_next = syncMode; // RULE1
        end
      end

      always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
          modeSeen_reg <= MODE_OTHER;
          mode_reg <= MODE_OTHER;
        end else begin
          modeSeen_reg <= modeSeen_next;
          mode_reg <= mode_next;
        end
      end

      always_comb begin
        mode = mode_reg;
        nibbleActive = (mode == MODE_NIBBLE); // RULE1
        hdlcActive = (mode == MODE_HDLC); // RULE1
        anyDefect = statusSync[LOS_POS] | statusSync[OOF_POS]
                  | statusSync[AIS_POS]; // RULE2 RULE3 RULE4

        // Clocks run at half the link rate and idle low when unused
        lineClk_next = nibbleActive ? ~lineClk_reg : CLOCK_RESET; // RULE13
        hdlcClk_next = hdlcActive ? ~hdlcClk_reg : CLOCK_RESET; // RULE13

        // Data loads only on the edge where the forwarded clock rises,
        // leaving a half period of set-up before its falling edge
        nibble_next = nibble_reg;
        if (!nibbleActive) begin
          nibble_next = NIBBLE_RESET; // RULE13
        end else if (!lineClk_reg && nibbleValid[c]) begin
          nibble_next = nibbleData[c]; // RULE5 RULE6 RULE7
        end

        hdlc_next = hdlc_reg;
        if (!hdlcActive) begin
          hdlc_next = HDLC_RESET; // RULE13
        end else if (!hdlcClk_reg && hdlcValid[c]) begin
          hdlc_next = hdlcData[c]; // RULE8 RULE9 RULE10
        end

      end

      always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
          lineClk_reg <= CLOCK_RESET;
          hdlcClk_reg <= CLOCK_RESET;
          nibble_reg <= NIBBLE_RESET;
          hdlc_reg <= HDLC_RESET;
        end else begin
          lineClk_reg <= lineClk_next;
          hdlcClk_reg <= hdlcClk_next;
          nibble_reg <= nibble_next;
          hdlc_reg <= hdlc_next;
        end
      end

      // Pins load from the same next values as the buses they mirror,
      // so a pin never lags its bus bit by a cycle
      always_comb begin
        red_next = pinSelect(mode, nibble_next[RED_ALARM_BIT],
                             hdlc_next[RED_ALARM_BIT],
                             anyDefect); // RULE1 RULE2 RULE3 RULE4
        frameLoss_next = pinSelect(mode, nibble_next[FRAME_LOSS_BIT], // RULE5
                                   hdlc_next[FRAME_LOSS_BIT], // RULE8
                                   statusSync[OOF_POS]); // RULE11 RULE12
      end

      always_ff @(posedge linkClk or posedge rst) begin
        if (rst) begin
          red_reg <= PIN_RESET;
          frameLoss_reg <= PIN_RESET;
        end else begin
          red_reg <= red_next;
          frameLoss_reg <= frameLoss_next;
        end
      end

      assign rxRedAlarmOut[c] = red_reg;
      assign rxFrameLossOut[c] = frameLoss_reg;
      assign rxNibbleBus[c] = nibble_reg;
      assign rxHdlcByteBus[c] = hdlc_reg;
      assign rxLineClockOut[c] = lineClk_reg;
      assign rxHdlcClockOut[c] = hdlcClk_reg;
    end
  endgenerate

endmodule

`default_nettype wire

// ---- test/rsdpm_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsdpm_checker
  import rsdpm_pkg::*;
#(parameter int N = 3) (
  input wire logic rst,
  input wire logic linkClk,
  input wire rsdpm_mode_type [N-1:0] channelMode,
  input wire logic [N-1:0] losDefect,
  input wire logic [N-1:0] oofDefect,
  input wire logic [N-1:0] aisDefect,
  input wire logic [N-1:0] rxRedAlarmOut,
  input wire logic [N-1:0] rxFrameLossOut,
  input wire logic [N-1:0][NIBBLE_WIDTH-1:0] rxNibbleBus,
  input wire logic [N-1:0][HDLC_WIDTH-1:0] rxHdlcByteBus,
  input wire logic [N-1:0] rxLineClockOut,
  input wire logic [N-1:0] rxHdlcClockOut
);
  default clocking @(posedge linkClk); endclocking
  default disable iff (rst);
  // Channel whose HDLC bus the bench exercises
  localparam int HC = (N > 1) ? 1 : 0;
  // Eight link cycles cover the mclk flop, sync flops and mode filter
  wire other = channelMode[0] == MODE_OTHER;
  wire quiet = !(losDefect[0] | oofDefect[0] | aisDefect[0]);
  los_red_a: assert property (
    (other && losDefect[0])[*8] |-> rxRedAlarmOut[0])
    else $error("red low under LOS");
  ais_red_a: assert property (
    (other && aisDefect[0])[*8] |-> rxRedAlarmOut[0])
    else $error("red low under AIS");
  red_clear_a: assert property (
    (other && quiet)[*8] |-> !rxRedAlarmOut[0])
    else $error("red high with no defect");
  oof_set_a: assert property (
    (other && oofDefect[0])[*8] |-> rxFrameLossOut[0])
    else $error("frame loss pin low");
  oof_clear_a: assert property (
    (other && !oofDefect[0])[*8] |-> !rxFrameLossOut[0])
    else $error("frame loss pin stuck");
  data_idle_a: assert property (
    other[*8] |-> rxNibbleBus[0] == 4'h0 && rxHdlcByteBus[0] == 8'h00
      && !rxLineClockOut[0] && !rxHdlcClockOut[0])
    else $error("data outputs active");
  nib_pins_a: assert property (
    rxLineClockOut[0] |-> rxNibbleBus[0][1] == rxFrameLossOut[0]
      && rxNibbleBus[0][3] == rxRedAlarmOut[0])
    else $error("pins differ from nibble");
  hdlc_pins_a: assert property (
    rxHdlcClockOut[HC] |-> rxHdlcByteBus[HC][1] == rxFrameLossOut[HC]
      && rxHdlcByteBus[HC][3] == rxRedAlarmOut[HC])
    else $error("pins differ from byte");
  nib_edge_a: assert property (
    $changed(rxNibbleBus[0]) |-> $rose(rxLineClockOut[0])
      || rxNibbleBus[0] == 4'h0)
    else $error("nibble moved off edge");
  hdlc_edge_a: assert property (
    $changed(rxHdlcByteBus[HC]) |-> $rose(rxHdlcClockOut[HC])
      || rxHdlcByteBus[HC] == 8'h00)
    else $error("byte moved off edge");
  one_func_a: assert property (
    (rxLineClockOut & rxHdlcClockOut) == '0)
    else $error("two functions at once");
endmodule
bind rsdpm_top rsdpm_checker #(.N(NUM_CHANNELS)) rsdpm_checker_i (.rst, .linkClk,
  .channelMode, .losDefect, .oofDefect, .aisDefect, .rxRedAlarmOut,
  .rxFrameLossOut, .rxNibbleBus, .rxHdlcByteBus, .rxLineClockOut,
  .rxHdlcClockOut);
`default_nettype wire

// ---- test/rsdpm_term_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsdpm_term_model #(parameter int W = 4) (
  input wire logic fwdClk,
  input wire logic [W-1:0] bus,
  output logic [W-1:0] captured
);
  // Mid-period sample, away from the edge where data moves
  always @(negedge fwdClk) begin
    captured <= bus;
  end
endmodule
`default_nettype wire

// ---- test/rsdpm_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rsdpm_top_tb;
  import rsdpm_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic linkClk = 1'b0;
  logic sel = 1'b0;
  rsdpm_mode_type [2:0] channelMode;
  logic [2:0] losDefect = 3'h0, oofDefect = 3'h0, aisDefect = 3'h0;
  logic [2:0] nibbleValid = 3'h0, hdlcValid = 3'h0;
  logic [2:0][3:0] nibbleData = 12'h000;
  logic [2:0][7:0] hdlcData = 24'h000000;
  wire logic [2:0] rxRedAlarmOut, rxFrameLossOut, rxLineClockOut;
  wire logic [2:0] rxHdlcClockOut;
  wire logic [2:0][3:0] rxNibbleBus;
  wire logic [2:0][7:0] rxHdlcByteBus;
  logic [3:0] gotNibble;
  logic [7:0] gotByte;
  int mismatches = 0, num_checks = 0;
  wire fwd = sel ? rxHdlcClockOut[1] : rxLineClockOut[0];
  rsdpm_top rsdpm_top_i (.mclk, .rst, .linkClk, .channelMode, .losDefect,
    .oofDefect, .aisDefect, .nibbleData, .nibbleValid, .hdlcData,
    .hdlcValid, .rxRedAlarmOut, .rxFrameLossOut, .rxNibbleBus,
    .rxHdlcByteBus, .rxLineClockOut, .rxHdlcClockOut);
  rsdpm_term_model #(.W(4)) nibble_term_i (.fwdClk(rxLineClockOut[0]),
    .bus(rxNibbleBus[0]), .captured(gotNibble));
  rsdpm_term_model #(.W(8)) hdlc_term_i (.fwdClk(rxHdlcClockOut[1]),
    .bus(rxHdlcByteBus[1]), .captured(gotByte));
  always #5 mclk = ~mclk;
  // Odd offset keeps link edges clear of mclk edges
  initial begin
    #2;
    forever #15 linkClk = ~linkClk;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task settle;
    repeat (20) @(posedge mclk);
  endtask
  task data_stream;
    logic [7:0] b;
    @(posedge mclk);
    channelMode[0] <= MODE_NIBBLE;
    channelMode[1] <= MODE_HDLC;
    oofDefect <= 3'h4;
    nibbleValid <= 3'h1;
    hdlcValid <= 3'h2;
    settle;
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      @(negedge fwd);
      for (int i = 0; i < 16; i++) begin
        b = {i[3:0], ~i[3:0]};
        @(posedge mclk);
        nibbleData[0] <= i[3:0];
        hdlcData[1] <= b;
        @(posedge fwd);
        @(negedge fwd);
        // The far side captures on this edge; read once it has landed
        @(posedge mclk);
        if (!sel) b = {4'h0, i[3:0]};
        chk(sel ? gotByte : {4'h0, gotNibble}, b);
        chk({6'h00, rxRedAlarmOut[s], rxFrameLossOut[s]}, {6'h00, b[3], b[1]});
      end
    end
    chk({7'h00, rxFrameLossOut[2]}, 8'h01);
    chk(rxHdlcByteBus[0], 8'h00);
  endtask
  task alarm_combos;
    logic [2:0] v;
    @(posedge mclk);
    channelMode[0] <= MODE_OTHER;
    channelMode[1] <= MODE_OTHER;
    // Undecoded code must fall back to the alarm functions
    channelMode[2] <= rsdpm_mode_type'(2'h2);
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 3; k++) begin
        v = 3'(i + k);
        losDefect[k] <= v[0];
        oofDefect[k] <= v[1];
        aisDefect[k] <= v[2];
      end
      repeat (2) settle;
      for (int k = 0; k < 3; k++) begin
        v = 3'(i + k);
        chk({7'h00, rxRedAlarmOut[k]}, {7'h00, |v});
        chk({7'h00, rxFrameLossOut[k]}, {7'h00, v[1]});
        chk({4'h0, rxNibbleBus[k]}, 8'h00);
        chk(rxHdlcByteBus[k], 8'h00);
        chk({6'h00, rxLineClockOut[k], rxHdlcClockOut[k]}, 8'h00);
      end
    end
  endtask
  task tally_and_finish;
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    for (int k = 0; k < 3; k++) channelMode[k] = MODE_OTHER;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    settle;
    data_stream;
    alarm_combos;
    tally_and_finish;
  end
  initial begin
    #200000;
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
